// *** verilog/fmap_pkg.sv ***
package fmap_pkg;
    // Object dictionary indices and subindices
    localparam logic [15:0] IDX_CMD_WORD  = 16'h60fe;  // Drive input command word
    localparam logic [15:0] IDX_SEL_BASE  = 16'h2090;  // First selectable object
    localparam logic [15:0] IDX_PDO_CAPS  = 16'h2ff0;  // PDO capability entry
    localparam logic [15:0] IDX_RX_MAP    = 16'h1600;  // First receive map object
    localparam logic [15:0] IDX_TX_MAP    = 16'h1a00;  // First transmit map object
    localparam logic [7:0]  SUB_COUNT     = 8'h00;
    localparam logic [7:0]  SUB_DATA      = 8'h01;
    localparam logic [7:0]  SUB_ADDR      = 8'h02;
    localparam logic [7:0]  CMD_ENTRIES   = 8'h01;     // Entries of command object
    localparam logic [7:0]  SEL_ENTRIES   = 8'h02;     // Entries of selectable object
    // Command word fields
    localparam int          CMD_TERM_LSB  = 18;        // Terminals three..eight
    localparam int          CMD_TERM_W    = 6;
    localparam int          CMD_EXTF_BIT  = 24;
    localparam int          CMD_FRST_BIT  = 25;
    localparam logic [31:0] CMD_USED_MASK = 32'h03fc_0000;
    // Drive command register layout
    localparam logic [15:0] DRV_CMD_REG   = 16'h0001;
    localparam int          DRV_TERM_LSB  = 6;
    localparam int          DRV_EXTF_BIT  = 2;
    localparam int          DRV_FRST_BIT  = 3;
    // Register address rules
    localparam logic [15:0] REG_DISABLED  = 16'hffff;
    localparam logic [15:0] REG_FREE_LIM  = 16'h0100;
    localparam logic [31:0] ADDR_RESET    = 32'hffff_ffff;
    // Emergency code for selection in progress
    localparam logic [15:0] EMCY_SEL_BUSY = 16'h6301;
    // PDO counts
    localparam logic [7:0]  NUM_RX_PDO    = 8'h0f;
    localparam logic [7:0]  NUM_TX_PDO    = 8'h10;
    localparam logic [7:0]  MAP_PER_DIR   = 8'h08;
    localparam logic [3:0]  MAP_RESET     = 4'h0;
    // Fetch engine states
    typedef enum logic [1:0] {FS_IDLE, FS_ISSUE, FS_WAIT} fmap_fetch_e;

    // Register tied to a fixed input object
    function automatic logic fmap_is_fixed(input logic [15:0] r);
        return (r == 16'h0001) || (r == 16'h0002) || (r == 16'h0004) ||
               (r == 16'h0005) || (r == 16'h0007) || (r == 16'h0008) ||
               (r == 16'h0009) || (r == 16'h0014);
    endfunction
endpackage

// *** verilog/fmap_check.sv ***
`timescale 1ns/1ps
// Legality of a proposed register selection for one object
module fmap_check import fmap_pkg::*; #(
    parameter int NUM_SEL = 4
) (
    // Proposed selection
    input  wire logic [31:0]              new_addr,
    input  wire logic                     is4,
    input  wire logic                     is_input,
    input  wire logic [$clog2(NUM_SEL)-1:0] self_idx,
    // Current selections of all objects
    input  wire logic [NUM_SEL-1:0][31:0] all_addr,
    // Verdict
    output logic                          ok
);
    logic [15:0] hi;  // First register (upper word)
    logic [15:0] lo;  // Second register
    logic        hi_en;
    logic        lo_en;

    // Combinational verdict
    always_comb begin
        hi    = new_addr[31:16];
        lo    = new_addr[15:0];
        hi_en = is4 && (hi != REG_DISABLED);
        lo_en = lo != REG_DISABLED;
        ok    = 1'b1;
        if ((hi_en && fmap_is_fixed(hi)) || (lo_en && fmap_is_fixed(lo))) begin
            ok = 1'b0;
        end
        if (hi_en && lo_en && hi == lo) begin
            ok = 1'b0;
        end
        for (int i = 0; i < NUM_SEL; i++) begin
            if (i != int'(self_idx)) begin
                if ((hi_en && (hi == all_addr[i][31:16] || hi == all_addr[i][15:0])) ||
                    (lo_en && (lo == all_addr[i][31:16] || lo == all_addr[i][15:0]))) begin
                    ok = 1'b0;
                end
            end
        end
        // input pairs above free range consecutive
        if (is4 && is_input && hi_en && lo_en &&
            (hi >= REG_FREE_LIM || lo >= REG_FREE_LIM) && lo != hi + 16'h0001) begin
            ok = 1'b0;
        end
        // output pair must not be consecutive
        if (is4 && !is_input && hi_en && lo_en &&
            (lo == hi + 16'h0001 || hi == lo + 16'h0001)) begin
            ok = 1'b0;
        end
    end
endmodule // fmap_check

// *** verilog/fmap_top.sv ***
`timescale 1ns/1ps
// Contract
// - Command word reserved bits ignored by device
// - Command bits copied to drive command register
// - Selectable object has count, data, address
// - Address write makes data mirror register
// - Address writable only preop and stopped
// - Operational refused during selection, emergency sent
// - Requests during selection answered with error
// - Input pairs above 00FF must be consecutive
// - Register mapped to one object only
// - Fixed input registers cannot be selected
// - PDO mapping configurable only in preop
// - Fifteen receive, sixteen transmit PDOs
// - Eight parameters mappable each direction
module fmap_top import fmap_pkg::*; #(
    parameter int NUM_SEL = 4                     // Selectable objects; odd ones 4-byte
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Object dictionary access from the master
    input  wire logic        od_req,
    input  wire logic        od_wr,
    input  wire logic [15:0] od_index,
    input  wire logic [7:0]  od_sub,
    input  wire logic [31:0] od_wdata,
    output logic             od_ack,
    output logic             od_err,
    output logic [31:0]      od_rdata,
    // Card and drive state
    input  wire logic        nmt_req_op,        // Pulse: go Operational
    input  wire logic        nmt_req_preop,     // Pulse: back to Pre-Operational
    input  wire logic        drive_running,
    output logic             nmt_operational,
    output logic             emcy_valid,
    output logic [15:0]      emcy_code,
    // Drive register space
    output logic             drv_cmd_wr,
    output logic [15:0]      drv_cmd_addr,
    output logic [15:0]      drv_cmd_bits,
    output logic             drv_rd_req,
    output logic [15:0]      drv_rd_addr,
    input  wire logic        drv_rd_valid,
    input  wire logic [15:0] drv_rd_data
);
    localparam int SW = $clog2(NUM_SEL);

    // Whole module state
    typedef struct packed {
        fmap_fetch_e                 fst;        // Fetch engine
        logic                        phase;      // Second half of 4-byte
        logic                        selecting;  // Content selection ongoing
        logic [SW-1:0]               sel_obj;    // Object whose selection waits
        logic                        sel_run;    // Engine busy on the selection fetch
        logic [SW-1:0]               obj;        // Object being fetched
        logic [SW-1:0]               rptr;       // Background refresh pointer
        logic [NUM_SEL-1:0][31:0]    addr;       // Address subindices
        logic [NUM_SEL-1:0][31:0]    data;       // Data subindices
        logic [31:0]                 cmd;        // Stored command word
        logic [14:0][3:0]            rx_cnt;     // Receive map entry counts
        logic [15:0][3:0]            tx_cnt;     // Transmit map entry counts
        logic                        op;
        logic                        ack;
        logic                        err;
        logic [31:0]                 rdata;
        logic                        emcy;
        logic                        cmd_wr;
        logic [15:0]                 cmd_bits;
        logic                        rd_req;
        logic [15:0]                 rd_addr;
    } fmap_state_s;

    fmap_state_s st_reg;   // Registered state
    fmap_state_s st_next;  // Next state
    logic        chk_ok;   // Selection legality
    logic [SW-1:0] wr_obj; // Addressed selectable object

    // Object number from index; width and direction from position
    function automatic logic is_four(input logic [SW-1:0] o);
        return o[0];
    endfunction
    function automatic logic is_in(input logic [SW-1:0] o);
        return int'(o) < NUM_SEL / 2;
    endfunction

    assign wr_obj = od_index[SW-1:0] - IDX_SEL_BASE[SW-1:0];

    fmap_check #(.NUM_SEL(NUM_SEL)) u_check (
        .new_addr (od_wdata),
        .is4      (is_four(wr_obj)),
        .is_input (is_in(wr_obj)),
        .self_idx (wr_obj),
        .all_addr (st_reg.addr),
        .ok       (chk_ok)
    );

    // Next state
    always_comb begin
        logic [15:0] half;
        logic        sel_hit;
        logic        preop_stop;
        half       = '0;
        st_next    = st_reg;
        st_next.ack    = 1'b0;
        st_next.err    = 1'b0;
        st_next.emcy   = 1'b0;
        st_next.cmd_wr = 1'b0;
        st_next.rd_req = 1'b0;
        sel_hit    = od_index >= IDX_SEL_BASE &&
                     od_index < IDX_SEL_BASE + 16'(NUM_SEL);
        preop_stop = !st_reg.op && !drive_running;

        // Card state changes
        if (nmt_req_preop) begin
            st_next.op = 1'b0;
        end else if (nmt_req_op) begin
            if (st_reg.selecting) begin
                st_next.emcy = 1'b1;
            end else begin
                st_next.op = 1'b1;
            end
        end

        // Dictionary requests
        if (od_req) begin
            st_next.ack = 1'b1;
            st_next.err = 1'b1;
            st_next.rdata = '0;
            if (st_reg.selecting) begin
                st_next.emcy = 1'b1;
            end else if (od_index == IDX_CMD_WORD) begin
                if (od_sub == SUB_COUNT && !od_wr) begin
                    st_next.err   = 1'b0;
                    st_next.rdata = {24'h00_0000, CMD_ENTRIES};
                end else if (od_sub == SUB_DATA) begin
                    st_next.err = 1'b0;
                    if (od_wr) begin
                        st_next.cmd    = od_wdata;
                        st_next.cmd_wr = 1'b1;
                        st_next.cmd_bits = '0;
                        st_next.cmd_bits[DRV_TERM_LSB +: CMD_TERM_W] =
                            od_wdata[CMD_TERM_LSB +: CMD_TERM_W];
                        st_next.cmd_bits[DRV_EXTF_BIT] = od_wdata[CMD_EXTF_BIT];
                        st_next.cmd_bits[DRV_FRST_BIT] = od_wdata[CMD_FRST_BIT];
                    end else begin
                        st_next.rdata = st_reg.cmd;
                    end
                end
            end else if (sel_hit) begin
                case (od_sub)
                    SUB_COUNT: begin
                        st_next.err   = od_wr;
                        st_next.rdata = {24'h00_0000, SEL_ENTRIES};
                    end
                    SUB_DATA: begin
                        st_next.err   = od_wr;
                        st_next.rdata = st_reg.data[wr_obj];
                    end
                    SUB_ADDR: begin
                        if (!od_wr) begin
                            st_next.err   = 1'b0;
                            st_next.rdata = st_reg.addr[wr_obj];
                        end else if (preop_stop && chk_ok) begin
                            st_next.err = 1'b0;
                            st_next.addr[wr_obj] = is_four(wr_obj) ? od_wdata
                                : {REG_DISABLED, od_wdata[15:0]};
                            // queue fetch; engine takes it once idle so
                            // an in-flight refresh read is never orphaned
                            st_next.selecting = 1'b1;
                            st_next.sel_obj   = wr_obj;
                        end
                    end
                    default: st_next.err = 1'b1;
                endcase
            end else if (od_index == IDX_PDO_CAPS && od_sub == SUB_DATA && !od_wr) begin
                st_next.err   = 1'b0;
                st_next.rdata = {NUM_RX_PDO, NUM_TX_PDO, MAP_PER_DIR, MAP_PER_DIR};
            end else if (od_sub == SUB_COUNT &&
                         ((od_index >= IDX_RX_MAP && od_index < IDX_RX_MAP + 16'(NUM_RX_PDO)) ||
                          (od_index >= IDX_TX_MAP && od_index < IDX_TX_MAP + 16'(NUM_TX_PDO)))) begin
                if (!od_wr) begin
                    st_next.err = 1'b0;
                    st_next.rdata[3:0] = od_index[11] ? st_reg.tx_cnt[od_index[3:0]]
                                                      : st_reg.rx_cnt[od_index[3:0]];
                end else if (!st_reg.op && od_wdata <= 32'(MAP_PER_DIR)) begin
                    st_next.err = 1'b0;
                    if (od_index[11]) begin
                        st_next.tx_cnt[od_index[3:0]] = od_wdata[3:0];
                    end else begin
                        st_next.rx_cnt[od_index[3:0]] = od_wdata[3:0];
                    end
                end
            end
        end

        // Fetch engine: selection fetch and background refresh
        case (st_reg.fst)
            FS_IDLE: begin
                // Pending selection first, else background refresh
                if (st_reg.selecting) begin
                    st_next.obj     = st_reg.sel_obj;
                    st_next.phase   = !is_four(st_reg.sel_obj);
                    st_next.sel_run = 1'b1;
                    st_next.fst     = FS_ISSUE;
                end else begin
                    st_next.obj   = st_reg.rptr;
                    st_next.phase = !is_four(st_reg.rptr);
                    st_next.fst   = FS_ISSUE;
                end
            end
            FS_ISSUE: begin
                half = st_reg.phase ? st_reg.addr[st_reg.obj][15:0]
                                    : st_reg.addr[st_reg.obj][31:16];
                if (half == REG_DISABLED) begin
                    // Disabled half reads as zero
                    if (st_reg.phase) begin
                        st_next.data[st_reg.obj][15:0] = '0;
                        st_next.fst       = FS_IDLE;
                        st_next.rptr      = st_reg.rptr + 1'b1;
                        // Only the selection fetch ends the selection
                        if (st_reg.sel_run) begin
                            st_next.selecting = 1'b0;
                            st_next.sel_run   = 1'b0;
                        end
                    end else begin
                        st_next.data[st_reg.obj][31:16] = '0;
                        st_next.phase = 1'b1;
                    end
                end else begin
                    st_next.rd_req  = 1'b1;
                    st_next.rd_addr = half;
                    st_next.fst     = FS_WAIT;
                end
            end
            FS_WAIT: begin
                if (drv_rd_valid) begin
                    if (st_reg.phase) begin
                        st_next.data[st_reg.obj][15:0] = drv_rd_data;
                        if (!is_four(st_reg.obj)) begin
                            st_next.data[st_reg.obj][31:16] = '0;
                        end
                        st_next.fst       = FS_IDLE;
                        st_next.rptr      = st_reg.rptr + 1'b1;
                        // Only the selection fetch ends the selection
                        if (st_reg.sel_run) begin
                            st_next.selecting = 1'b0;
                            st_next.sel_run   = 1'b0;
                        end
                    end else begin
                        st_next.data[st_reg.obj][31:16] = drv_rd_data;
                        st_next.phase = 1'b1;
                        st_next.fst   = FS_ISSUE;
                    end
                end
            end
            default: st_next.fst = FS_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg      <= '0;
            st_reg.fst  <= FS_IDLE;
            st_reg.addr <= {NUM_SEL{ADDR_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register; emergency code and command address are constants
    assign od_ack          = st_reg.ack;
    assign od_err          = st_reg.err;
    assign od_rdata        = st_reg.rdata;
    assign nmt_operational = st_reg.op;
    assign emcy_valid      = st_reg.emcy;
    assign emcy_code       = EMCY_SEL_BUSY;
    assign drv_cmd_wr      = st_reg.cmd_wr;
    assign drv_cmd_addr    = DRV_CMD_REG;
    assign drv_cmd_bits    = st_reg.cmd_bits;
    assign drv_rd_req      = st_reg.rd_req;
    assign drv_rd_addr     = st_reg.rd_addr;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_cmd_copy;
        od_req && od_wr && od_index == IDX_CMD_WORD && od_sub == SUB_DATA && !st_reg.selecting
        |=> drv_cmd_wr && drv_cmd_bits[DRV_TERM_LSB +: CMD_TERM_W]
            == $past(od_wdata[CMD_TERM_LSB +: CMD_TERM_W]);
    endproperty
    a_cmd_copy: assert property (p_cmd_copy) else $error("command bits not copied");
    property p_reserved;
        drv_cmd_wr |-> (drv_cmd_bits & 16'h f033) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit leaked");
    property p_op_refused;
        nmt_req_op && !nmt_req_preop && st_reg.selecting |=> emcy_valid && !nmt_operational
            && emcy_code == EMCY_SEL_BUSY;
    endproperty
    a_op_refused: assert property (p_op_refused) else $error("operational not refused");
    property p_busy_err;
        od_req && st_reg.selecting |=> od_ack && od_err && emcy_valid;
    endproperty
    a_busy_err: assert property (p_busy_err) else $error("busy request not refused");
    property p_addr_locked;
        od_req && od_wr && od_sub == SUB_ADDR && (nmt_operational || drive_running)
        |=> od_err && $stable(st_reg.addr);
    endproperty
    a_addr_locked: assert property (p_addr_locked) else $error("address written when locked");
    sequence s_fetch_req;
        drv_rd_req;
    endsequence
    sequence s_req_drop;
        !drv_rd_req;
    endsequence
    property p_no_double_req;
        s_fetch_req |=> s_req_drop;
    endproperty
    a_no_double_req: assert property (p_no_double_req) else $error("double read request");
    logic sel_hit_w;  // Request aims at a selectable object
    assign sel_hit_w = od_index >= IDX_SEL_BASE && od_index < IDX_SEL_BASE + 16'(NUM_SEL);
    property p_reject_keep;
        od_req && od_wr && sel_hit_w && od_sub == SUB_ADDR && !chk_ok |=> $stable(st_reg.addr)
            ##0 od_err;
    endproperty
    a_reject_keep: assert property (p_reject_keep) else $error("rejected mapping changed");
    property p_map_locked;
        od_req && od_wr && od_sub == SUB_COUNT && nmt_operational && !st_reg.selecting
            && (od_index[15:8] == IDX_RX_MAP[15:8] || od_index[15:8] == IDX_TX_MAP[15:8])
        |=> od_err;
    endproperty
    a_map_locked: assert property (p_map_locked) else $error("map changed while operational");
endmodule // fmap_top

// *** dv/fmap_drive_model.sv ***
`timescale 1ns/1ps
// Drive register space: one read outstanding, answers after a delay
module fmap_drive_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Read channel from the card
    input  wire logic        drv_rd_req,
    input  wire logic [15:0] drv_rd_addr,
    input  wire logic        slow,        // Long answer latency
    output logic             drv_rd_valid,
    output logic [15:0]      drv_rd_data
);
    logic [7:0]  wait_cnt;  // Cycles to answer
    logic        busy;      // Read in flight
    logic [15:0] addr_q;    // Held address
    // Answer late; data toggles outside valid so a capture one cycle late never matches
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            wait_cnt <= 8'h00;
            addr_q <= 16'h0000;
            drv_rd_valid <= 1'b0;
            drv_rd_data <= 16'h0000;
        end else begin
            drv_rd_valid <= 1'b0;
            drv_rd_data <= ~drv_rd_data;
            if (drv_rd_req && !busy) begin
                busy <= 1'b1;
                addr_q <= drv_rd_addr;
                wait_cnt <= slow ? 8'h28 : 8'h02;
            end else if (busy && wait_cnt == 8'h00) begin
                busy <= 1'b0;
                drv_rd_valid <= 1'b1;
                drv_rd_data <= addr_q ^ 16'ha5c3;
            end else if (busy) begin
                wait_cnt <= wait_cnt - 8'h01;
            end
        end
    end
endmodule // fmap_drive_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top import fmap_pkg::*;;
    logic clock = 0, rst_n = 0, od_req = 0, od_wr = 0, nmt_req_op = 0, nmt_req_preop = 0;
    logic drive_running = 0, slow = 0, od_ack, od_err, nmt_operational, emcy_valid;
    logic drv_cmd_wr, drv_rd_req, drv_rd_valid, err_q;
    logic [15:0] od_index = 0, emcy_code, drv_cmd_addr, drv_cmd_bits, drv_rd_addr, drv_rd_data;
    logic [7:0]  od_sub = 0;
    logic [31:0] od_wdata = 0, od_rdata, rd_q;
    int error_cnt = 0, comparisons = 0, cyc = 0, emcy_cnt = 0;
    // Design and drive model
    fmap_top #(.NUM_SEL(4)) fmap_top_i (.clock(clock), .rst_n(rst_n), .od_req(od_req),
        .od_wr(od_wr), .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata),
        .od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata), .nmt_req_op(nmt_req_op),
        .nmt_req_preop(nmt_req_preop), .drive_running(drive_running),
        .nmt_operational(nmt_operational), .emcy_valid(emcy_valid), .emcy_code(emcy_code),
        .drv_cmd_wr(drv_cmd_wr), .drv_cmd_addr(drv_cmd_addr), .drv_cmd_bits(drv_cmd_bits),
        .drv_rd_req(drv_rd_req), .drv_rd_addr(drv_rd_addr), .drv_rd_valid(drv_rd_valid),
        .drv_rd_data(drv_rd_data));
    fmap_drive_model fmap_drive_model_i (.clock(clock), .rst_n(rst_n), .drv_rd_req(drv_rd_req),
        .drv_rd_addr(drv_rd_addr), .slow(slow), .drv_rd_valid(drv_rd_valid),
        .drv_rd_data(drv_rd_data));
    always #5 clock = ~clock;
    // Emergency pulses and hang guard
    always @(posedge clock) begin
        cyc++;
        if (emcy_valid === 1'b1) emcy_cnt++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    function automatic logic [15:0] rv(input logic [15:0] a);
        return a ^ 16'ha5c3;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One dictionary transfer; answer sampled one cycle after the request
    task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s,
                      input logic [31:0] d);
        @(posedge clock);
        od_req <= 1'b1;
        od_wr <= w;
        od_index <= i;
        od_sub <= s;
        od_wdata <= d;
        @(posedge clock);
        od_req <= 1'b0;
        #1;
        chk("od_ack", 32'h1, {31'h0, od_ack});
        rd_q = od_rdata;
        err_q = od_err;
    endtask
    task automatic sel_set(input int o, input logic [31:0] a, input logic e);
        od(1'b1, IDX_SEL_BASE + 16'(o), SUB_ADDR, a);
        chk("sel_err", {31'h0, e}, {31'h0, err_q});
    endtask
    // Poll data; refused polls while selecting must each raise an emergency
    task automatic sel_wait(input int o, input logic [31:0] e);
        int n = 0, c0 = emcy_cnt;
        do begin
            od(1'b0, IDX_SEL_BASE + 16'(o), SUB_DATA, 32'h0);
            if (err_q !== 1'b0) n++;
        end while (err_q !== 1'b0 && n < 200);
        repeat (2) @(posedge clock);
        chk("sel_data", e, rd_q);
        chk("emcy_cnt", 32'(n), 32'(emcy_cnt - c0));
    endtask
    task automatic nmt(input logic op);
        @(posedge clock);
        if (op) nmt_req_op <= 1'b1; else nmt_req_preop <= 1'b1;
        @(posedge clock);
        nmt_req_op <= 1'b0;
        nmt_req_preop <= 1'b0;
        #1;
    endtask
    task automatic t_cmd();
        logic [15:0] e;
        for (int b = 18; b < 26; b++) begin
            e = (b < 24) ? 16'(1 << (b - 12)) : (b == 24) ? 16'h0004 : 16'h0008;
            od(1'b1, IDX_CMD_WORD, SUB_DATA, 32'(1) << b);
            chk("cmd_wr", 32'h1, {31'h0, drv_cmd_wr});
            chk("cmd_bits", {16'h0, e}, {16'h0, drv_cmd_bits});
            chk("cmd_addr", {16'h0, DRV_CMD_REG}, {16'h0, drv_cmd_addr});
        end
        od(1'b1, IDX_CMD_WORD, SUB_DATA, 32'hfc03_ffff);
        chk("cmd_rsvd", 32'h0, {16'h0, drv_cmd_bits});
        od(1'b0, IDX_CMD_WORD, SUB_COUNT, 32'h0);
        chk("cmd_cnt", {24'h0, CMD_ENTRIES}, rd_q);
        od(1'b0, IDX_SEL_BASE, SUB_COUNT, 32'h0);
        chk("sel_cnt", {24'h0, SEL_ENTRIES}, rd_q);
        od(1'b1, IDX_SEL_BASE, SUB_COUNT, 32'h0);
        chk("cnt_ro", 32'h1, {31'h0, err_q});
    endtask
    task automatic t_caps();
        od(1'b0, IDX_PDO_CAPS, SUB_DATA, 32'h0);
        chk("caps", 32'h0f10_0808, rd_q);
        od(1'b1, IDX_RX_MAP + 16'h000e, SUB_COUNT, 32'h8);
        chk("rx_last", 32'h0, {31'h0, err_q});
        od(1'b1, IDX_RX_MAP + 16'h000f, SUB_COUNT, 32'h1);
        chk("rx_over", 32'h1, {31'h0, err_q});
        od(1'b1, IDX_TX_MAP + 16'h000f, SUB_COUNT, 32'h9);
        chk("tx_nine", 32'h1, {31'h0, err_q});
    endtask
    task automatic t_select();
        logic [15:0] fx [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0005,
                                16'h0007, 16'h0008, 16'h0009, 16'h0014};
        sel_set(0, 32'h0000_0047, 1'b0);
        sel_wait(0, {16'h0, rv(16'h0047)});
        sel_set(1, 32'h0201_0202, 1'b0);
        sel_wait(1, {rv(16'h0201), rv(16'h0202)});
        sel_set(1, 32'h0202_0201, 1'b1);
        sel_set(1, 32'h0201_0203, 1'b1);
        sel_set(1, 32'h0202_0202, 1'b1);
        sel_wait(1, {rv(16'h0201), rv(16'h0202)});
        sel_set(1, 32'h0200_ffff, 1'b0);
        sel_wait(1, {rv(16'h0200), 16'h0});
        sel_set(1, 32'h0030_0010, 1'b0);
        sel_wait(1, {rv(16'h0030), rv(16'h0010)});
        foreach (fx[k]) sel_set(0, {16'h0, fx[k]}, 1'b1);
        sel_set(2, 32'h0000_0047, 1'b1);
        sel_set(3, 32'h0300_0305, 1'b0);
        sel_wait(3, {rv(16'h0300), rv(16'h0305)});
        sel_wait(0, {16'h0, rv(16'h0047)});
    endtask
    task automatic t_state();
        drive_running <= 1'b1;
        sel_set(0, 32'h0000_0060, 1'b1);
        drive_running <= 1'b0;
        nmt(1'b1);
        chk("op", 32'h1, {31'h0, nmt_operational});
        sel_set(0, 32'h0000_0061, 1'b1);
        od(1'b1, IDX_RX_MAP, SUB_COUNT, 32'h1);
        chk("map_op", 32'h1, {31'h0, err_q});
        nmt(1'b0);
        chk("preop", 32'h0, {31'h0, nmt_operational});
        sel_wait(0, {16'h0, rv(16'h0047)});
        slow <= 1'b1;
        sel_set(2, 32'h0000_0050, 1'b0);
        nmt(1'b1);
        chk("emcy", 32'h1, {31'h0, emcy_valid});
        chk("emcy_code", {16'h0, EMCY_SEL_BUSY}, {16'h0, emcy_code});
        chk("op_refused", 32'h0, {31'h0, nmt_operational});
        @(posedge clock);
        #1;
        sel_wait(2, {16'h0, rv(16'h0050)});
        slow <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        t_cmd();
        t_caps();
        t_select();
        t_state();
        give_verdict();
    end
endmodule // tb_top
